// File: asr_pkg.sv
/*
 Constants, types and the register map of the amplifier status and control register bank.
 Assumes a single 25 MHz system clock and an I2C controller on the far side of two pins.
*/
package asr_pkg;

   // ----------------------------------------------------------------
   // Target address and register map
   // ----------------------------------------------------------------
   localparam logic [6:0] TARGET_ADDR = 7'h6C;
   localparam logic [7:0] REG_FAULT = 8'h01;
   localparam logic [7:0] REG_STATUS = 8'h02;
   localparam logic [7:0] REG_CTRL = 8'h03;
   localparam logic [7:0] FAULT_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] CTRL_RESET = 8'h78;
   localparam logic [7:0] CTRL_RSVD_MASK = 8'h06;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int FLT_DIAG_BIT = 2;
   localparam int FLT_OC_BIT = 3;
   localparam int FLT_UV_BIT = 4;
   localparam int FLT_OV_BIT = 5;
   localparam int FLT_DC_BIT = 6;
   localparam int FLT_OT_BIT = 7;
   localparam int ST_SHORT_SUP_BIT = 0;
   localparam int ST_SHORT_GND_BIT = 1;
   localparam int ST_OPEN_BIT = 2;
   localparam int ST_SHORTED_BIT = 3;
   localparam int ST_FAULT_BIT = 4;
   localparam int ST_DIAG_BIT = 5;
   localparam int ST_MUTE_BIT = 6;
   localparam int ST_PLAY_BIT = 7;
   localparam int CTRL_FREQ_BIT = 0;
   localparam int CTRL_LIM_LSB = 3;
   localparam int CTRL_LIM_MSB = 5;
   localparam int CTRL_GAIN_LSB = 6;
   localparam int CTRL_GAIN_MSB = 7;

   // ----------------------------------------------------------------
   // Field codes
   // ----------------------------------------------------------------
   localparam logic [1:0] GAIN_20DB = 2'h0;
   localparam logic [1:0] GAIN_26DB = 2'h1;
   localparam logic [1:0] GAIN_32DB = 2'h2;
   localparam logic [1:0] GAIN_36DB = 2'h3;
   localparam logic FREQ_400KHZ = 1'b0;
   localparam logic FREQ_500KHZ = 1'b1;
   localparam logic [2:0] LIM_5V0 = 3'h0;
   localparam logic [2:0] LIM_5V9 = 3'h1;
   localparam logic [2:0] LIM_7V0 = 3'h2;
   localparam logic [2:0] LIM_8V4 = 3'h3;
   localparam logic [2:0] LIM_9V8 = 3'h4;
   localparam logic [2:0] LIM_11V8 = 3'h5;
   localparam logic [2:0] LIM_14V0 = 3'h6;
   localparam logic [2:0] LIM_OFF = 3'h7;

   // ----------------------------------------------------------------
   // Link framing
   // ----------------------------------------------------------------
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam int SYNC_W = 16;
   localparam logic [15:0] SYNC_RESET = 16'hC000;

   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_DEV_ADDR = 9'h002,
      ST_ACK_DEV = 9'h004,
      ST_REG_ADDR = 9'h008,
      ST_ACK_REG = 9'h010,
      ST_WR_DATA = 9'h020,
      ST_ACK_WR = 9'h040,
      ST_RD_DATA = 9'h080,
      ST_RD_ACK = 9'h100
   } asr_state_e;

endpackage

// File: asr_sync.sv
/*
 Two-flop synchroniser, one per bit, for pins and flags from outside the clock domain.
 Assumes every input is a slow level compared with the 25 MHz clock.
*/
module asr_sync #(
   parameter int WIDTH = 16,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         logic meta_q;
         logic stable_q;
         always_ff @(posedge sys_clk)
         begin
            if (sys_rst)
            begin
               meta_q <= RESET_VAL[i];
               stable_q <= RESET_VAL[i];
            end
            else
            begin
               meta_q <= async_in[i];
               stable_q <= meta_q;
            end
         end
         assign sync_out[i] = stable_q;
      end
   endgenerate

endmodule

// File: asr_line_watch.sv
/*
 Finds clock edges and start and stop conditions on the synchronised two-wire link.
 Assumes both inputs are already synchronised to the system clock.
*/
module asr_line_watch (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic scl_s,
   input wire logic sda_s,
   output logic scl_rise,
   output logic scl_fall,
   output logic start_det,
   output logic stop_det
);

   logic scl_q;
   logic sda_q;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   // A data change while the clock stays high frames a transfer.
   assign scl_rise = scl_s & ~scl_q;
   assign scl_fall = ~scl_s & scl_q;
   assign start_det = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_det = scl_s & scl_q & ~sda_q & sda_s;

endmodule

// File: asr_regs_top.sv
/*
 Two-wire target with the fault, status and control registers of the amplifier.
 Assumes event and mode flags are levels from the analog side, asynchronous to sys_clk,
 and a controller clocking the link well below a quarter of the system clock.
*/
module asr_regs_top (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic diag_fault_evt,
   input wire logic overcurrent_evt,
   input wire logic undervolt_evt,
   input wire logic overvolt_evt,
   input wire logic dc_offset_evt,
   input wire logic overtemp_evt,
   input wire logic short_to_supply,
   input wire logic short_to_ground,
   input wire logic open_load,
   input wire logic shorted_load,
   input wire logic fault_mode,
   input wire logic diag_running,
   input wire logic mute_mode,
   input wire logic play_mode,
   output logic [asr_pkg::CTRL_GAIN_MSB-asr_pkg::CTRL_GAIN_LSB:0] gain_sel,
   output logic switch_freq_sel,
   output logic [asr_pkg::CTRL_LIM_MSB-asr_pkg::CTRL_LIM_LSB:0] limiter_code
);
   import asr_pkg::*;

   // ----------------------------------------------------------------
   // Input synchronisation and line events
   // ----------------------------------------------------------------
   logic [SYNC_W-1:0] raw_in;
   logic [SYNC_W-1:0] sync_in;
   logic scl_s;
   logic sda_s;
   logic [5:0] evt_s;
   logic [7:0] live_s;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   assign raw_in = {scl_in, sda_in, overtemp_evt, dc_offset_evt, overvolt_evt, undervolt_evt,
                    overcurrent_evt, diag_fault_evt, play_mode, mute_mode, diag_running,
                    fault_mode, shorted_load, open_load, short_to_ground, short_to_supply};

   asr_sync #(
      .WIDTH(SYNC_W),
      .RESET_VAL(SYNC_RESET)
   ) u_sync (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .async_in(raw_in),
      .sync_out(sync_in)
   );

   assign scl_s = sync_in[15];
   assign sda_s = sync_in[14];
   assign evt_s = sync_in[13:8];
   assign live_s = sync_in[7:0];

   asr_line_watch u_watch (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .scl_s(scl_s),
      .sda_s(sda_s),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall),
      .start_det(start_det),
      .stop_det(stop_det)
   );

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   asr_state_e state_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] rx_q;
   logic [7:0] tx_q;
   logic [7:0] ptr_q;
   logic rw_q;
   logic sda_low_q;
   logic [7:0] fault_q;
   logic [7:0] status_q;
   logic [7:0] ctrl_q;
   logic byte_done;
   logic addr_match;
   logic load_evt;
   logic [7:0] load_ptr;
   logic [7:0] rd_byte;
   logic wr_ctrl;
   logic fault_rd_clr;
   logic [7:0] fault_set;

   assign byte_done = (bit_cnt_q == BITS_PER_BYTE);
   assign addr_match = (rx_q[7:1] == TARGET_ADDR);

   // A new byte is fetched on the ack of a read address or of a read byte.
   assign load_evt = scl_fall & (((state_q == ST_ACK_DEV) & rw_q) |
                                 ((state_q == ST_RD_ACK) & ~rx_q[0]));
   assign load_ptr = (state_q == ST_RD_ACK) ? ptr_q + 8'h01 : ptr_q;

   always_comb
   begin
      unique case (load_ptr)
         REG_FAULT: rd_byte = fault_q;
         REG_STATUS: rd_byte = status_q;
         REG_CTRL: rd_byte = ctrl_q;
         default: rd_byte = UNMAPPED_READ;
      endcase
   end

   assign wr_ctrl = scl_fall & (state_q == ST_WR_DATA) & byte_done & (ptr_q == REG_CTRL);
   assign fault_rd_clr = load_evt & (load_ptr == REG_FAULT);

   // ----------------------------------------------------------------
   // Link state machine
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         state_q <= ST_IDLE;
         bit_cnt_q <= '0;
         rx_q <= '0;
         tx_q <= '0;
         ptr_q <= '0;
         rw_q <= 1'b0;
         sda_low_q <= 1'b0;
      end
      else if (stop_det)
      begin
         state_q <= ST_IDLE;
         sda_low_q <= 1'b0;
      end
      else if (start_det)
      begin
         state_q <= ST_DEV_ADDR;
         bit_cnt_q <= '0;
         sda_low_q <= 1'b0;
      end
      else
      begin
         unique case (state_q)
            ST_IDLE:
            begin
               bit_cnt_q <= '0;
            end
            ST_DEV_ADDR, ST_REG_ADDR, ST_WR_DATA:
            begin
               if (scl_rise)
               begin
                  rx_q <= {rx_q[6:0], sda_s};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end
               else if (scl_fall && byte_done)
               begin
                  bit_cnt_q <= '0;
                  if (state_q == ST_DEV_ADDR)
                  begin
                     sda_low_q <= addr_match;
                     rw_q <= rx_q[0];
                     state_q <= addr_match ? ST_ACK_DEV : ST_IDLE;
                  end
                  else if (state_q == ST_REG_ADDR)
                  begin
                     sda_low_q <= 1'b1;
                     ptr_q <= rx_q;
                     state_q <= ST_ACK_REG;
                  end
                  else
                  begin
                     sda_low_q <= 1'b1;
                     state_q <= ST_ACK_WR;
                  end
               end
            end
            ST_ACK_DEV:
            begin
               if (scl_fall)
               begin
                  bit_cnt_q <= '0;
                  if (rw_q)
                  begin
                     tx_q <= rd_byte;
                     sda_low_q <= ~rd_byte[7];
                     state_q <= ST_RD_DATA;
                  end
                  else
                  begin
                     sda_low_q <= 1'b0;
                     state_q <= ST_REG_ADDR;
                  end
               end
            end
            ST_ACK_REG, ST_ACK_WR:
            begin
               if (scl_fall)
               begin
                  sda_low_q <= 1'b0;
                  state_q <= ST_WR_DATA;
               end
            end
            ST_RD_DATA:
            begin
               if (scl_rise)
               begin
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end
               else if (scl_fall)
               begin
                  if (byte_done)
                  begin
                     bit_cnt_q <= '0;
                     sda_low_q <= 1'b0;
                     state_q <= ST_RD_ACK;
                  end
                  else
                  begin
                     tx_q <= {tx_q[6:0], 1'b0};
                     sda_low_q <= ~tx_q[6];
                  end
               end
            end
            ST_RD_ACK:
            begin
               if (scl_rise)
               begin
                  rx_q <= {rx_q[6:0], sda_s};
               end
               else if (scl_fall)
               begin
                  if (!rx_q[0])
                  begin
                     ptr_q <= load_ptr;
                     tx_q <= rd_byte;
                     sda_low_q <= ~rd_byte[7];
                     state_q <= ST_RD_DATA;
                  end
                  else
                  begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            default:
            begin
               state_q <= ST_IDLE;
               sda_low_q <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Fault latches
   // ----------------------------------------------------------------
   always_comb
   begin
      fault_set = FAULT_RESET;
      fault_set[FLT_DIAG_BIT] = evt_s[0];
      fault_set[FLT_OC_BIT] = evt_s[1];
      fault_set[FLT_UV_BIT] = evt_s[2];
      fault_set[FLT_OV_BIT] = evt_s[3];
      fault_set[FLT_DC_BIT] = evt_s[4];
      fault_set[FLT_OT_BIT] = evt_s[5];
   end

   // Reading the fault register clears it; an event in the same cycle survives.
   // reserved bits stay zero
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         fault_q <= FAULT_RESET;
      end
      else
      begin
         fault_q <= (fault_rd_clr ? FAULT_RESET : fault_q) | fault_set;
      end
   end

   // ----------------------------------------------------------------
   // Live status
   // ----------------------------------------------------------------
   // zero when nothing active
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         status_q <= STATUS_RESET;
      end
      else
      begin
         status_q[ST_SHORT_SUP_BIT] <= live_s[0];
         status_q[ST_SHORT_GND_BIT] <= live_s[1];
         status_q[ST_OPEN_BIT] <= live_s[2];
         status_q[ST_SHORTED_BIT] <= live_s[3];
         status_q[ST_FAULT_BIT] <= live_s[4];
         status_q[ST_DIAG_BIT] <= live_s[5];
         status_q[ST_MUTE_BIT] <= live_s[6];
         status_q[ST_PLAY_BIT] <= live_s[7];
      end
   end

   // ----------------------------------------------------------------
   // Control register and outputs
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         ctrl_q <= CTRL_RESET;
      end
      else if (wr_ctrl)
      begin
         ctrl_q <= (rx_q & ~CTRL_RSVD_MASK) | (CTRL_RESET & CTRL_RSVD_MASK);
      end
   end

   assign switch_freq_sel = ctrl_q[CTRL_FREQ_BIT];
   assign limiter_code = ctrl_q[CTRL_LIM_MSB:CTRL_LIM_LSB];
   assign gain_sel = ctrl_q[CTRL_GAIN_MSB:CTRL_GAIN_LSB];
   // The pin is only ever pulled low; a released line is left to the pull-up.
   assign sda_out = 1'b0;
   assign sda_oe_n = ~sda_low_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_addr_byte_done;
      (state_q == ST_DEV_ADDR) && scl_fall && byte_done;
   endsequence

   chk_addr_ack_own: assert property (s_addr_byte_done ##0 addr_match |=>
      (state_q == ST_ACK_DEV) && !sda_oe_n)
      else $error("own address not acknowledged");
   chk_addr_ignore_other: assert property (s_addr_byte_done ##0 !addr_match |=>
      (state_q == ST_IDLE) && sda_oe_n)
      else $error("foreign address acknowledged");
   chk_decode_ctrl: assert property (load_evt && load_ptr == REG_CTRL |=>
      tx_q == $past(ctrl_q))
      else $error("control register read wrong");
   chk_fault_rsvd: assert property (fault_q[1:0] == 2'h0)
      else $error("reserved fault bits set");
   chk_fault_latch: assert property (fault_set[FLT_OT_BIT] |=> fault_q[FLT_OT_BIT])
      else $error("overtemperature not latched");
   chk_fault_set_wins: assert property (fault_rd_clr && fault_set[FLT_OC_BIT] |=>
      fault_q[FLT_OC_BIT])
      else $error("event lost on clear");
   chk_status_live: assert property (##1 status_q == $past(live_s))
      else $error("status not following flags");
   chk_ctrl_rsvd: assert property (ctrl_q[2:1] == CTRL_RESET[2:1])
      else $error("reserved control bits changed");
   chk_ro_write: assert property (scl_fall && state_q == ST_WR_DATA && byte_done
      && ptr_q != REG_CTRL |=> $stable(ctrl_q) && !sda_oe_n)
      else $error("read-only write took effect");
   chk_seq_advance: assert property ((state_q == ST_RD_ACK) && scl_fall && !rx_q[0] |=>
      ptr_q == $past(ptr_q) + 8'h01)
      else $error("pointer did not advance");

endmodule

// File: asr_i2c_ctrl.sv
/*
 Behavioural two-wire controller that clocks the link and drives the data line.
 Assumes the bench resolves the open-drain data line with a pull-up.
*/
module asr_i2c_ctrl (
   input wire logic sys_clk,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   timeunit 1ns;
   timeprecision 100ps;

   // The clock idles high and the data line is released between frames.
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic w(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic start();
      scl <= 1'b0;
      w(4);
      sda_low <= 1'b0;
      w(4);
      scl <= 1'b1;
      w(4);
      sda_low <= 1'b1;
      w(4);
   endtask

   task automatic stop();
      scl <= 1'b0;
      w(4);
      sda_low <= 1'b1;
      w(4);
      scl <= 1'b1;
      w(4);
      sda_low <= 1'b0;
      w(4);
   endtask

   task automatic xfer(input logic [7:0] d, input logic rel9, output logic [7:0] q,
                       output logic ack);
      for (int i = 7; i >= -1; i--)
      begin
         scl <= 1'b0;
         w(2);
         sda_low <= (i >= 0) ? ~d[i & 7] : ~rel9;
         w(2);
         scl <= 1'b1;
         w(2);
         if (i >= 0)
            q[i & 7] = sda;
         else
            ack = sda;
         w(2);
      end
   endtask
endmodule

// File: asr_regs_top_bench.sv
/*
 Self-checking bench for the register bank, with a reference model of the registers.
 Assumes the controller model in asr_i2c_ctrl and a pull-up on the data line.
*/
module asr_regs_top_bench;
   timeunit 1ns;
   timeprecision 100ps;

   logic sys_clk = 1'b0;
   logic sys_rst;
   logic scl;
   logic ctl_low;
   logic sda_out;
   logic sda_oe_n;
   logic sda;
   logic [5:0] evt;
   logic [7:0] st;
   logic [1:0] gain_sel;
   logic switch_freq_sel;
   logic [2:0] limiter_code;
   logic [31:0] lfsr = 32'h0000_f7be;
   logic [7:0] ctrl_m = 8'h78;
   logic [7:0] fault_m = 8'h00;
   logic [7:0] rdq[$];
   int num_errors = 0;
   int tests_run = 0;

   always #20 sys_clk = ~sys_clk;
   assign sda = ~(ctl_low | (~sda_oe_n & ~sda_out));

   asr_i2c_ctrl ctl (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(ctl_low));

   asr_regs_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .diag_fault_evt(evt[0]),
      .overcurrent_evt(evt[1]), .undervolt_evt(evt[2]), .overvolt_evt(evt[3]),
      .dc_offset_evt(evt[4]), .overtemp_evt(evt[5]), .short_to_supply(st[0]),
      .short_to_ground(st[1]), .open_load(st[2]), .shorted_load(st[3]),
      .fault_mode(st[4]), .diag_running(st[5]), .mute_mode(st[6]), .play_mode(st[7]),
      .gain_sel(gain_sel), .switch_freq_sel(switch_freq_sel),
      .limiter_code(limiter_code));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] nxt();
      lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h0040_0007 : 32'h0000_0000);
      return lfsr;
   endfunction

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic hdr(input logic [7:0] r);
      logic [7:0] q;
      logic a;
      ctl.start();
      ctl.xfer(8'hd8, 1'b1, q, a);
      chk("write address ack", 8'h00, {7'h0, a});
      ctl.xfer(r, 1'b1, q, a);
      chk("register ack", 8'h00, {7'h0, a});
   endtask

   task automatic wr(input logic [7:0] r, input logic [7:0] d);
      logic [7:0] q;
      logic a;
      hdr(r);
      ctl.xfer(d, 1'b1, q, a);
      chk("data ack", 8'h00, {7'h0, a});
      ctl.stop();
      if (r == 8'h03)
         ctrl_m = d & 8'hf9;
   endtask

   task automatic rd(input logic [7:0] r, input int n);
      logic [7:0] q;
      logic a;
      hdr(r);
      ctl.start();
      ctl.xfer(8'hd9, 1'b1, q, a);
      chk("read address ack", 8'h00, {7'h0, a});
      for (int i = 0; i < n; i++)
      begin
         ctl.xfer(8'hff, i == n - 1, q, a);
         rdq.push_back(q);
      end
      ctl.stop();
   endtask

   task automatic end_of_test();
      $display("Checks %0d, errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial
   begin
      logic [31:0] v;
      logic [7:0] q;
      logic a;
      sys_rst = 1'b1;
      evt = 6'h00;
      st = 8'h00;
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk("gain", 8'h01, {6'h0, gain_sel});
      chk("limiter", 8'h07, {5'h0, limiter_code});
      chk("freq", 8'h00, {7'h0, switch_freq_sel});
      rd(8'h01, 3);
      chk("fault reset", fault_m, rdq.pop_front());
      chk("status reset", 8'h00, rdq.pop_front());
      chk("ctrl reset", ctrl_m, rdq.pop_front());
      for (int i = 0; i < 8; i++)
      begin
         v = nxt();
         wr(8'h03, {i[1:0], i[2:0], v[2:0]});
         chk("gain", {6'h0, ctrl_m[7:6]}, {6'h0, gain_sel});
         chk("limiter", {5'h0, ctrl_m[5:3]}, {5'h0, limiter_code});
         chk("freq", {7'h0, ctrl_m[0]}, {7'h0, switch_freq_sel});
         rd(8'h03, 1);
         chk("ctrl readback", ctrl_m, rdq.pop_front());
      end
      // A reset in mid-run must drop a latched fault and restore the control defaults.
      evt <= 6'h20;
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b1;
      evt <= 6'h00;
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b0;
      ctrl_m = 8'h78;
      repeat (4) @(posedge sys_clk);
      chk("gain after reset", {6'h0, ctrl_m[7:6]}, {6'h0, gain_sel});
      chk("limiter after reset", {5'h0, ctrl_m[5:3]}, {5'h0, limiter_code});
      chk("freq after reset", {7'h0, ctrl_m[0]}, {7'h0, switch_freq_sel});
      rd(8'h01, 1);
      chk("fault after reset", 8'h00, rdq.pop_front());
      wr(8'h01, 8'hff);
      wr(8'h02, 8'hff);
      wr(8'h05, 8'h00);
      rd(8'h03, 1);
      chk("ctrl kept", ctrl_m, rdq.pop_front());
      rd(8'h05, 1);
      chk("unmapped read", 8'h00, rdq.pop_front());
      ctl.start();
      ctl.xfer(8'hda, 1'b1, q, a);
      chk("foreign address nack", 8'h01, {7'h0, a});
      ctl.stop();
      for (int j = 0; j < 6; j++)
      begin
         evt <= 6'h01 << j;
         repeat (4) @(posedge sys_clk);
         evt <= 6'h00;
         repeat (4) @(posedge sys_clk);
         fault_m = 8'h04 << j;
         rd(8'h01, 1);
         chk("fault latch", fault_m, rdq.pop_front());
         fault_m = 8'h00;
         rd(8'h01, 1);
         chk("fault cleared", fault_m, rdq.pop_front());
      end
      // An event still active when its bit is read and cleared must keep the bit set.
      evt <= 6'h02;
      repeat (4) @(posedge sys_clk);
      fault_m = 8'h08;
      rd(8'h01, 1);
      chk("fault held", fault_m, rdq.pop_front());
      evt <= 6'h00;
      repeat (4) @(posedge sys_clk);
      rd(8'h01, 1);
      chk("fault set wins", fault_m, rdq.pop_front());
      fault_m = 8'h00;
      rd(8'h01, 1);
      chk("fault cleared", fault_m, rdq.pop_front());
      for (int k = 0; k < 12; k++)
      begin
         v = nxt();
         st <= (k < 8) ? 8'h01 << k : v[7:0];
         repeat (4) @(posedge sys_clk);
         rd(8'h02, 1);
         chk("status", st, rdq.pop_front());
      end
      end_of_test();
   end

   initial
   begin
      repeat (40000) @(posedge sys_clk);
      num_errors++;
      end_of_test();
   end
endmodule
